// ### src/irs_pkg.sv
// Shared constants for the integrator converter serial readout block.
// Assumes a single 20 MHz system clock and a host that supplies the data clock.
`default_nettype none

package irs_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	// Data-ready latency after a convert-strobe edge, in nanoseconds.
	localparam int LAT_SLOW_NS = 276_400;
	localparam int LAT_FAST_NS = 138_200;
	// Longest times round down to whole cycles.
	localparam int LAT_SLOW_CYC = LAT_SLOW_NS / CLK_PERIOD_NS;
	localparam int LAT_FAST_CYC = LAT_FAST_NS / CLK_PERIOD_NS;
	localparam int LAT_W = 13;
	// Internal divided clock used to time data-ready.
	localparam int DIV_RATIO = 4;
	localparam logic [1:0] DIV_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Data format
	// ----------------------------------------------------------------
	localparam int CHANNELS = 64;
	localparam int WORD_WIDE = 20;
	localparam int WORD_NARROW = 16;
	localparam int SAMPLE_W = 20;
	localparam logic [21:0] CODE_OFFSET = 22'h010000;
	localparam logic [19:0] CODE_MAX = 20'hFFFFF;
	localparam logic [19:0] CODE_MIN = 20'h00000;
	localparam int FORMAT_BIT = 8;

endpackage

`default_nettype wire

// ### src/irs_readout.sv
// Serial result readout for a 64-channel current-input converter.
// Assumes the converter core streams signed channel samples after each
// convert-strobe edge, and that the host data clock and chain input are
// synchronous to clk (data clock far slower than clk).
`default_nettype none

module irs_readout import irs_pkg::*; #(
	parameter int LAT_SLOW = LAT_SLOW_CYC,
	parameter int LAT_FAST = LAT_FAST_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic deviceResetN,
	input wire logic formatWide,
	input wire logic versionFast,
	input wire logic convertStrobe,
	input wire logic shiftClock,
	input wire logic chainIn,
	input wire logic sampleValid,
	output logic sampleReady,
	input wire logic [SAMPLE_W-1:0] sampleData,
	output logic resultReadyN,
	output logic serialOut
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Offset binary with clamping at both ends of the code range.
	function automatic logic [19:0] toCode(input logic [SAMPLE_W-1:0] s);
		logic [21:0] sum;
		sum = {{2{s[SAMPLE_W-1]}}, s} + CODE_OFFSET;
		if (sum[21]) begin
			toCode = CODE_MIN;
		end else if (sum[20]) begin
			toCode = CODE_MAX;
		end else begin
			toCode = sum[19:0];
		end
	endfunction

	// MSB-first bit pick; narrow words simply stop before the low nibble.
	function automatic logic pickBit(input logic [19:0] w, input logic [4:0] b);
		pickBit = w[5'(WORD_WIDE - 1) - b];
	endfunction

	// ----------------------------------------------------------------
	// Two-entry buffer between converter core and capture bank
	// ----------------------------------------------------------------
	logic [19:0] buf0_ff, buf1_ff, nxt_buf0, nxt_buf1;
	logic [1:0] bufCnt_ff, nxt_bufCnt;
	logic drainReady;
	logic fire;

	// The capture bank stalls while full, which backs up into the source. A frozen
	// clock enable refuses as well, so no word is taken that cannot be stored.
	assign sampleReady = clkEn && (bufCnt_ff != 2'h2);

	always_comb begin
		nxt_buf0 = buf0_ff;
		nxt_buf1 = buf1_ff;
		nxt_bufCnt = bufCnt_ff;
		if (drainReady && bufCnt_ff != 2'h0) begin
			nxt_buf0 = buf1_ff;
			nxt_bufCnt = nxt_bufCnt - 2'h1;
		end
		if (sampleValid && sampleReady) begin
			if (nxt_bufCnt == 2'h0) begin
				nxt_buf0 = toCode(sampleData);
			end else begin
				nxt_buf1 = toCode(sampleData);
			end
			nxt_bufCnt = nxt_bufCnt + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge deviceResetN) begin
		if (!deviceResetN) begin
			buf0_ff <= '0;
			buf1_ff <= '0;
			bufCnt_ff <= 2'h0;
		end else if (rst) begin
			buf0_ff <= '0;
			buf1_ff <= '0;
			bufCnt_ff <= 2'h0;
		end else if (clkEn) begin
			buf0_ff <= nxt_buf0;
			buf1_ff <= nxt_buf1;
			bufCnt_ff <= nxt_bufCnt;
		end
	end

	// ----------------------------------------------------------------
	// Data-ready timing from the strobe and the divided clock
	// ----------------------------------------------------------------
	logic strobePrev_ff, nxt_strobePrev;
	logic [LAT_W-1:0] latCnt_ff, nxt_latCnt;
	logic latBusy_ff, nxt_latBusy;
	logic [1:0] divPhase_ff, nxt_divPhase;

	// Ready fires only on a divided-clock tick, so its phase against the
	// strobe can slip by up to three system-clock periods; hosts should poll it.
	assign fire = latBusy_ff && (latCnt_ff == '0) && (divPhase_ff == DIV_RESET);

	always_comb begin
		nxt_strobePrev = convertStrobe;
		nxt_divPhase = 2'(divPhase_ff + 2'h1);
		nxt_latCnt = latCnt_ff;
		nxt_latBusy = latBusy_ff;
		if (convertStrobe != strobePrev_ff) begin
			nxt_latCnt = versionFast ? LAT_W'(LAT_FAST) : LAT_W'(LAT_SLOW);
			nxt_latBusy = 1'b1;
		end else if (fire) begin
			nxt_latBusy = 1'b0;
		end else if (latBusy_ff && latCnt_ff != '0) begin
			nxt_latCnt = latCnt_ff - LAT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge deviceResetN) begin
		if (!deviceResetN) begin
			strobePrev_ff <= 1'b0;
			latCnt_ff <= '0;
			latBusy_ff <= 1'b0;
			divPhase_ff <= DIV_RESET;
		end else if (rst) begin
			strobePrev_ff <= 1'b0;
			latCnt_ff <= '0;
			latBusy_ff <= 1'b0;
			divPhase_ff <= DIV_RESET;
		end else if (clkEn) begin
			strobePrev_ff <= nxt_strobePrev;
			latCnt_ff <= nxt_latCnt;
			latBusy_ff <= nxt_latBusy;
			divPhase_ff <= nxt_divPhase;
		end
	end

	// ----------------------------------------------------------------
	// Two result banks: one captures, the other is shifted out
	// ----------------------------------------------------------------
	logic [19:0] mem_ff [2*CHANNELS];
	logic [19:0] nxt_mem [2*CHANNELS];
	logic bankSel_ff, nxt_bankSel;
	logic [6:0] wrIdx_ff, nxt_wrIdx;

	// Writes pause in the swap cycle so no word straddles the two banks.
	assign drainReady = (wrIdx_ff < 7'(CHANNELS)) && !fire;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_bankSel = bankSel_ff;
		nxt_wrIdx = wrIdx_ff;
		if (drainReady && bufCnt_ff != 2'h0) begin
			nxt_mem[{bankSel_ff, wrIdx_ff[5:0]}] = buf0_ff;
			nxt_wrIdx = wrIdx_ff + 7'h01;
		end
		if (fire) begin
			// Unread output bank becomes the next capture bank and is overwritten.
			nxt_bankSel = ~bankSel_ff;
			nxt_wrIdx = 7'h00;
		end
	end

	always_ff @(posedge clk or negedge deviceResetN) begin
		if (!deviceResetN) begin
			bankSel_ff <= 1'b0;
			wrIdx_ff <= 7'h00;
			for (int i = 0; i < 2 * CHANNELS; i++) begin
				mem_ff[i] <= '0;
			end
		end else if (rst) begin
			bankSel_ff <= 1'b0;
			wrIdx_ff <= 7'h00;
			for (int i = 0; i < 2 * CHANNELS; i++) begin
				mem_ff[i] <= '0;
			end
		end else if (clkEn) begin
			bankSel_ff <= nxt_bankSel;
			wrIdx_ff <= nxt_wrIdx;
			mem_ff <= nxt_mem;
		end
	end

	// ----------------------------------------------------------------
	// Serial shifter driven by falling edges of the host data clock
	// ----------------------------------------------------------------
	logic shiftPrev_ff, nxt_shiftPrev;
	logic readyN_ff, nxt_readyN;
	logic serial_ff, nxt_serial;
	logic [6:0] shWord_ff, nxt_shWord;
	logic [4:0] shBit_ff, nxt_shBit;
	logic shiftFall;
	logic [4:0] lastBit;

	assign shiftFall = shiftPrev_ff && !shiftClock;
	// Format bit selects the word length.
	assign lastBit = formatWide ? 5'(WORD_WIDE - 1) : 5'(WORD_NARROW - 1);
	assign resultReadyN = readyN_ff;
	assign serialOut = serial_ff;

	always_comb begin
		nxt_shiftPrev = shiftClock;
		nxt_readyN = readyN_ff;
		nxt_serial = serial_ff;
		nxt_shWord = shWord_ff;
		nxt_shBit = shBit_ff;
		if (fire) begin
			// New result: present word 0 MSB before the first falling edge.
			nxt_readyN = 1'b0;
			nxt_shWord = 7'h00;
			nxt_shBit = 5'h00;
			nxt_serial = pickBit(mem_ff[{bankSel_ff, 6'h00}], 5'h00);
		end else if (shiftFall) begin
			nxt_readyN = 1'b1;
			if (shWord_ff < 7'(CHANNELS)) begin
				if (shBit_ff == lastBit) begin
					nxt_shBit = 5'h00;
					nxt_shWord = shWord_ff + 7'h01;
				end else begin
					nxt_shBit = shBit_ff + 5'h01;
				end
			end
			if (nxt_shWord < 7'(CHANNELS)) begin
				nxt_serial = pickBit(mem_ff[{~bankSel_ff, nxt_shWord[5:0]}], nxt_shBit);
			end else begin
				// Own words done: pass the upstream device's bits through.
				nxt_serial = chainIn;
			end
		end
	end

	always_ff @(posedge clk or negedge deviceResetN) begin
		if (!deviceResetN) begin
			shiftPrev_ff <= 1'b0;
			readyN_ff <= 1'b1;
			serial_ff <= 1'b0;
			shWord_ff <= 7'(CHANNELS);
			shBit_ff <= 5'h00;
		end else if (rst) begin
			shiftPrev_ff <= 1'b0;
			readyN_ff <= 1'b1;
			serial_ff <= 1'b0;
			shWord_ff <= 7'(CHANNELS);
			shBit_ff <= 5'h00;
		end else if (clkEn) begin
			shiftPrev_ff <= nxt_shiftPrev;
			readyN_ff <= nxt_readyN;
			serial_ff <= nxt_serial;
			shWord_ff <= nxt_shWord;
			shBit_ff <= nxt_shBit;
		end
	end

endmodule

`default_nettype wire

// ### test/irs_readout_asserts.sv
// Concurrent checks on the readout ports.
// Assumes clkEn stays high and no strobe edge lands while a ready is still pending.
`default_nettype none
module irs_readout_asserts import irs_pkg::*; #(
	parameter int LAT_SLOW = LAT_SLOW_CYC,
	parameter int LAT_FAST = LAT_FAST_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic deviceResetN,
	input wire logic formatWide,
	input wire logic versionFast,
	input wire logic convertStrobe,
	input wire logic shiftClock,
	input wire logic chainIn,
	input wire logic sampleValid,
	input wire logic sampleReady,
	input wire logic [SAMPLE_W-1:0] sampleData,
	input wire logic resultReadyN,
	input wire logic serialOut
);
	timeunit 1ns;
	timeprecision 1ns;
	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	logic shPrev_ff, stPrev_ff, fired_ff, nxt_fired, fall;
	logic [13:0] cnt_ff, nxt_cnt;
	int lat;
	// The count saturates, so long idle stretches never wrap into a false window.
	always_comb begin
		fall = shPrev_ff && !shiftClock;
		lat = versionFast ? LAT_FAST : LAT_SLOW;
		nxt_cnt = (cnt_ff == 14'h3FFF) ? cnt_ff : cnt_ff + 14'h1;
		nxt_fired = fired_ff || !resultReadyN;
		if (convertStrobe != stPrev_ff) begin
			nxt_cnt = 14'h1;
			nxt_fired = 1'b0;
		end
	end
	// Registers only.
	always_ff @(posedge clk) begin
		shPrev_ff <= (rst || !deviceResetN) ? 1'b0 : shiftClock;
		stPrev_ff <= convertStrobe;
		cnt_ff <= (rst || !deviceResetN) ? 14'h3FFF : nxt_cnt;
		fired_ff <= (rst || !deviceResetN) ? 1'b1 : nxt_fired;
	end
	chk_ready_clear: assert property (@(posedge clk) disable iff (rst || !deviceResetN)
		fall && !resultReadyN |-> ##[1:2] resultReadyN) else $error("ready not cleared");
	chk_ready_stands: assert property (@(posedge clk) disable iff (rst || !deviceResetN)
		$rose(resultReadyN) |-> $past(fall) || $past(fall, 2)) else $error("ready rose early");
	chk_ready_early: assert property (@(posedge clk) disable iff (rst || !deviceResetN)
		$fell(resultReadyN) |-> cnt_ff >= lat && cnt_ff <= lat + 6) else $error("ready off time");
	chk_ready_late: assert property (@(posedge clk) disable iff (rst || !deviceResetN)
		cnt_ff == lat + 7 |-> fired_ff) else $error("ready missing");
	chk_ready_once: assert property (@(posedge clk) disable iff (rst || !deviceResetN)
		$fell(resultReadyN) |-> !fired_ff) else $error("second ready");
	chk_out_steady: assert property (@(posedge clk) disable iff (rst || !deviceResetN)
		$changed(serialOut) |-> $past(fall) || $past(fall, 2) || $fell(resultReadyN))
		else $error("output moved without shift");
	chk_sync_reset: assert property (@(posedge clk) disable iff (!deviceResetN)
		rst |=> resultReadyN && !serialOut && sampleReady) else $error("bad reset values");
	chk_async_reset: assert property (@(posedge clk) disable iff (rst)
		!deviceResetN |-> resultReadyN && !serialOut && sampleReady) else $error("async reset");
endmodule
bind irs_readout irs_readout_asserts #(.LAT_SLOW(LAT_SLOW), .LAT_FAST(LAT_FAST)) i_chk (
	.clk(clk), .rst(rst), .clkEn(clkEn), .deviceResetN(deviceResetN),
	.formatWide(formatWide), .versionFast(versionFast), .convertStrobe(convertStrobe),
	.shiftClock(shiftClock), .chainIn(chainIn), .sampleValid(sampleValid),
	.sampleReady(sampleReady), .sampleData(sampleData), .resultReadyN(resultReadyN),
	.serialOut(serialOut));
`default_nettype wire

// ### test/irs_host_model.sv
// Host model: shifts results out with the data clock and feeds the chain input.
// Assumes it is started only after ready has fallen.
`default_nettype none
module irs_host_model (
	input wire logic clk,
	input wire logic serialOut,
	output var logic shiftClock,
	output var logic chainIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic got [0:1287];
	initial begin
		shiftClock = 1'b0;
		chainIn = 1'b0;
	end
	// Five system cycles per bit, so each phase easily outlasts one clk cycle.
	// The start index lets a paused readout resume where it stopped.
	task automatic read(input int first, input int n);
		for (int i = first; i < first + n; i++) begin
			got[i] = serialOut;
			@(negedge clk) shiftClock = 1'b1;
			chainIn = ((i + 1) % 3 == 0);
			@(negedge clk);
			@(negedge clk) shiftClock = 1'b0;
			@(negedge clk);
			@(negedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ### test/irs_readout_tb.sv
// Bench: core samples go in, the host model reads words and chain bits out.
// Assumes short latency parameters; the clock enable is held high.
`default_nettype none
module irs_readout_tb import irs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LS = 100;
	localparam int LF = 60;
	logic clk = 1'b0, rst = 1'b1, devRstN = 1'b1, formatWide = 1'b1, versionFast = 1'b0;
	logic convertStrobe = 1'b0, sampleValid = 1'b0, sampleReady, resultReadyN, serialOut;
	logic shiftClock, chainIn;
	logic [SAMPLE_W-1:0] sampleData = '0, smp [0:191];
	int nErrors = 0, samplesChecked = 0, nAcc = 0;
	always #25 clk = ~clk;
	irs_readout #(.LAT_SLOW(LS), .LAT_FAST(LF)) i_dut (.clk(clk), .rst(rst), .clkEn(1'b1),
		.deviceResetN(devRstN), .formatWide(formatWide), .versionFast(versionFast),
		.convertStrobe(convertStrobe), .shiftClock(shiftClock), .chainIn(chainIn),
		.sampleValid(sampleValid), .sampleReady(sampleReady), .sampleData(sampleData),
		.resultReadyN(resultReadyN), .serialOut(serialOut));
	irs_host_model i_host (.clk(clk), .serialOut(serialOut), .shiftClock(shiftClock),
		.chainIn(chainIn));
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [19:0] code(input logic [19:0] s, input logic wide);
		int v;
		v = $signed(s) + 65536;
		v = v < 0 ? 0 : v > 1048575 ? 1048575 : v;
		return wide ? 20'(v) : 20'(v >> 4);
	endfunction
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Offers words back to back with random gaps; corner codes open each bank.
	task automatic feed(input int first, input int cnt);
		for (int c = first; c < first + cnt; c++) begin
			smp[c] = c % 64 == 0 ? 20'h00000 : c % 64 == 1 ? 20'h80000 : c % 64 == 2
				? 20'h7FFFF : c % 64 == 3 ? 20'hF0000 : 20'($urandom);
			sampleData = smp[c];
			sampleValid = 1'b1;
			// Ready is read while it stands, before the edge that takes the word.
			while (sampleReady !== 1'b1) @(negedge clk);
			@(posedge clk);
			nAcc++;
			@(negedge clk);
			if ($urandom % 4 == 0) begin
				sampleValid = 1'b0;
				@(negedge clk);
			end
		end
		sampleValid = 1'b0;
	endtask
	// Quiet gap with the data clock parked low, then a strobe edge.
	task automatic strobe();
		repeat (40) @(negedge clk);
		convertStrobe = ~convertStrobe;
	endtask
	// Polls ready rather than timing from the strobe, so the phase slip never matters.
	task automatic pollReady();
		for (int t = 0; t < LS + 10 && resultReadyN !== 1'b0; t++) @(negedge clk);
		check("ready", 20'(resultReadyN), 20'h0);
	endtask
	// One conversion: strobe, poll ready, read and compare. A split readout stops
	// before the chain bits and lets the next strobe edge pass in the pause.
	task automatic round(input int base, input logic split);
		logic [19:0] w;
		int wd;
		wd = formatWide ? 20 : 16;
		wait (nAcc >= base + 64);
		strobe();
		pollReady();
		if (split) begin
			i_host.read(0, wd * 64);
			strobe();
			repeat (40) @(negedge clk);
			// The rest ends well before the next ready can fall.
			i_host.read(wd * 64, 8);
		end else begin
			i_host.read(0, wd * 64 + 8);
		end
		for (int c = 0; c < 64; c++) begin
			w = '0;
			for (int b = 0; b < wd; b++) w = {w[18:0], i_host.got[c * wd + b]};
			check("word", w, code(smp[base + c], formatWide));
		end
		for (int j = wd * 64; j < wd * 64 + 8; j++)
			check("chain", 20'(i_host.got[j]), 20'(j % 3 == 0));
		check("ready", 20'(resultReadyN), 20'h1);
		$display("round %0d done", base);
	endtask
	initial begin
		void'($urandom(57843));
		repeat (4) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		fork feed(0, 66); join_none
		wait (nAcc == 66);
		repeat (4) @(negedge clk);
		check("refused", 20'(sampleReady), 20'h0);
		round(0, 1'b0);
		formatWide = 1'b0;
		versionFast = 1'b1;
		fork feed(66, 62); join_none
		round(64, 1'b0);
		devRstN = 1'b0;
		repeat (2) @(negedge clk);
		check("reset", {18'h0, resultReadyN, serialOut}, 20'h2);
		repeat (18) @(negedge clk);
		devRstN = 1'b1;
		// Format and version are plain pins here, so restating them is the reprogramming.
		formatWide = 1'b0;
		versionFast = 1'b0;
		$display("reset done");
		fork feed(128, 64); join_none
		round(128, 1'b1);
		// The strobe in the pause starts a fresh result, whose ready must follow.
		pollReady();
		wrapUp();
	end
	// Three rounds need about 18000 cycles; this cuts a hang well beyond that.
	initial begin
		repeat (40000) @(posedge clk);
		nErrors++;
		wrapUp();
	end
endmodule
`default_nettype wire
